/* ndm_core.sv */
// module: data memory, system register block, config space and stack
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RULE1] stack holds five return address slots plus one interrupt slot
// [RULE2] calls and table references push the return address; here only call and irq pulses push
// [RULE3] interrupt saves address and status word, then clears bank and status
// [RULE4] seven-bit address, upper three bits row, lower four bits column
// [RULE5] every location stores a single four-bit nibble
// [RULE6] 40h to 6eh has no storage; reads give zero, writes dropped
// [RULE7] work register sits in memory at the row picked by the pointer
// [RULE8] pointer is 7dh nibble plus upper three bits of 7eh
// [RULE9] high pointer part picks bank, low pointer bits pick the row
// [RULE10] system register block lives at 74h to 7fh of data memory
// [RULE11] constant-zero system bits always read zero and ignore writes
// [RULE12] config space is 128 nibbles, rows 0 to 7, columns 0 to f
// [RULE13] config addresses 00h to 3fh hold peripheral configuration
// [RULE14] config 40h to 7fh is the same storage as data memory there
// [RULE15] dedicated read and write ops reach the config space
// [RULE16] reset clears address, bank, index, pointer and status fields
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module ndm_core (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire ndm_pkg::ndm_req_t req,
    input  wire ndm_pkg::ndm_flow_t flow,
    output logic [3:0]             rdata,
    output logic                   rvalid,
    output logic [9:0]             pop_pc,
    output logic                   stack_full,
    output logic [15:0]            table_address_pointer,
    output logic [3:0]             memory_bank_select,
    output logic [11:0]            index_and_row_pointer,
    output logic [6:0]             gen_reg_pointer,
    output logic [3:0]             processor_status_flags
);

    //////////////////////////////////////////////////////////////////////////
    // address formation
    logic [6:0]  eff_addr;
    logic        is_cfg_op;
    logic        wr_en;
    logic [2:0]  gr_row;
    logic        in_hole;
    logic        in_sys;
    logic        in_ctl;

    assign is_cfg_op = (req.op == ndm_pkg::NDM_OP_CFG_RD) ||
                       (req.op == ndm_pkg::NDM_OP_CFG_WR); // [RULE15]
    assign gr_row    = gen_reg_pointer[2:0]; // [RULE9]

    always_comb begin
        // work register: pointer row, column from instruction
        if (req.use_gr && !is_cfg_op) begin
            eff_addr = {gr_row, req.col}; // [RULE7] [RULE4]
        end else begin
            eff_addr = req.addr;
        end
    end

    assign wr_en   = (req.op == ndm_pkg::NDM_OP_CFG_WR) ||
                     ((req.op == ndm_pkg::NDM_OP_MOV) && req.wr);
    // the control area is reached only by the dedicated ops
    assign in_ctl  = is_cfg_op && (eff_addr <= ndm_pkg::CFG_HI); // [RULE13]
    assign in_hole = (eff_addr >= ndm_pkg::HOLE_LO) &&
                     (eff_addr <= ndm_pkg::HOLE_HI); // [RULE6]
    assign in_sys  = (eff_addr >= ndm_pkg::SYS_LO); // [RULE10]

    //////////////////////////////////////////////////////////////////////////
    // storage: general data memory and control area
    logic [3:0] dmem [0:63];  // [RULE5]
    logic [3:0] cmem [0:63];  // [RULE12]
    logic [3:0] port_nib [0:4]; // 6fh to 73h, user-visible nibbles

    always_ff @(posedge sys_clk) begin
        if (wr_en && !in_hole && !in_sys && !eff_addr[6]) begin
            if (in_ctl) begin
                cmem[eff_addr[5:0]] <= req.wdata;
            end else if (!is_cfg_op) begin
                dmem[eff_addr[5:0]] <= req.wdata;
            end
        end
    end

    // 6fh..73h: shared by both views, so one array serves both
    logic [2:0] pidx;
    assign pidx = 3'(eff_addr - 7'h6F);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 5; i++) begin
                port_nib[i] <= ndm_pkg::NIB_RST;
            end
        end else if (wr_en && eff_addr[6] && !in_hole && !in_sys) begin
            port_nib[pidx] <= req.wdata; // [RULE14]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // system register block
    logic [3:0]  ar_r [0:3];
    logic [3:0]  win_r;
    logic [3:0]  bank_r;
    logic [3:0]  ix_r [0:2];
    logic [3:0]  rph_r;
    logic [3:0]  rpl_r;
    logic [3:0]  psw_r;
    logic        sys_wr;
    logic [9:0]  stk_r [0:4]; // [RULE1]
    logic [2:0]  sp_r;
    logic [9:0]  istk_pc_r;
    logic [4:0]  psw_save_r;

    assign sys_wr = wr_en && in_sys;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) begin
                ar_r[i] <= ndm_pkg::NIB_RST; // [RULE16]
            end
        end else if (sys_wr && eff_addr <= ndm_pkg::AR0_ADDR) begin
            unique case (eff_addr)
                ndm_pkg::AR3_ADDR:
                    ar_r[3] <= req.wdata & ndm_pkg::AR3_MASK; // [RULE11]
                7'h75:
                    ar_r[2] <= req.wdata & ndm_pkg::AR2_MASK; // [RULE11]
                7'h76:
                    ar_r[1] <= req.wdata & ndm_pkg::AR_MASK;
                default:
                    ar_r[0] <= req.wdata & ndm_pkg::AR_MASK;
            endcase
        end
    end

    // window nibble is left undefined at reset
    always_ff @(posedge sys_clk) begin
        if (sys_wr && eff_addr == ndm_pkg::WIN_ADDR) begin
            win_r <= req.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bank_r <= ndm_pkg::NIB_RST; // [RULE16]
        end else if (flow.irq) begin
            bank_r <= ndm_pkg::NIB_RST; // [RULE3]
        end else if (sys_wr && eff_addr == ndm_pkg::BANK_ADDR) begin
            bank_r <= req.wdata & ndm_pkg::BANK_MASK; // [RULE11]
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 3; i++) begin
                ix_r[i] <= ndm_pkg::NIB_RST; // [RULE16]
            end
        end else if (sys_wr && eff_addr == ndm_pkg::IXH_ADDR) begin
            ix_r[2] <= req.wdata & ndm_pkg::IXH_MASK; // [RULE11]
        end else if (sys_wr && eff_addr == ndm_pkg::IXM_ADDR) begin
            ix_r[1] <= req.wdata;
        end else if (sys_wr && eff_addr == ndm_pkg::IXL_ADDR) begin
            ix_r[0] <= req.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rph_r <= ndm_pkg::NIB_RST; // [RULE16]
            rpl_r <= ndm_pkg::NIB_RST;
        end else if (flow.reti) begin
            rpl_r[0] <= psw_save_r[4]; // shared status bit comes back
        end else if (flow.irq) begin
            rpl_r[0] <= 1'b0; // [RULE3]
        end else if (sys_wr && eff_addr == ndm_pkg::RPH_ADDR) begin
            rph_r <= req.wdata & ndm_pkg::RPH_MASK; // [RULE11]
        end else if (sys_wr && eff_addr == ndm_pkg::RPL_ADDR) begin
            rpl_r <= req.wdata & ndm_pkg::RPL_MASK; // [RULE8]
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            psw_r <= ndm_pkg::NIB_RST; // [RULE16]
        end else if (flow.reti) begin
            psw_r <= psw_save_r[3:0];
        end else if (flow.irq) begin
            psw_r <= ndm_pkg::NIB_RST; // [RULE3]
        end else if (sys_wr && eff_addr == ndm_pkg::PSW_ADDR) begin
            psw_r <= req.wdata & ndm_pkg::PSW_MASK;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // stack: five return slots and one interrupt slot

    // pushes past the fifth slot are dropped; software must not nest deeper
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sp_r <= 3'h0;
        end else if ((flow.call || flow.irq) && sp_r < 3'(ndm_pkg::STK_D)) begin
            sp_r <= sp_r + 3'h1; // [RULE2]
        end else if ((flow.ret || flow.reti) && sp_r != 3'h0) begin
            sp_r <= sp_r - 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if ((flow.call || flow.irq) && sp_r < 3'(ndm_pkg::STK_D)) begin
            stk_r[sp_r] <= flow.ret_pc; // [RULE2] [RULE3]
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            istk_pc_r  <= 10'h000;
            psw_save_r <= 5'h00;
        end else if (flow.irq) begin
            istk_pc_r  <= flow.ret_pc;
            psw_save_r <= {rpl_r[0], psw_r}; // [RULE3]
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pop_pc <= 10'h000;
        end else if ((flow.ret || flow.reti) && sp_r != 3'h0) begin
            pop_pc <= stk_r[sp_r - 3'h1];
        end
    end

    assign stack_full = (sp_r == 3'(ndm_pkg::STK_D));

    //////////////////////////////////////////////////////////////////////////
    // read path
    logic [3:0] rd_nxt;

    always_comb begin
        rd_nxt = ndm_pkg::HOLE_RD;
        if (in_hole) begin
            rd_nxt = ndm_pkg::HOLE_RD; // [RULE6]
        end else if (in_ctl) begin
            rd_nxt = cmem[eff_addr[5:0]];
        end else if (!eff_addr[6]) begin
            rd_nxt = is_cfg_op ? cmem[eff_addr[5:0]] : dmem[eff_addr[5:0]];
        end else if (!in_sys) begin
            rd_nxt = port_nib[pidx]; // [RULE14]
        end else begin
            unique case (eff_addr)
                7'h74:   rd_nxt = ar_r[3];
                7'h75:   rd_nxt = ar_r[2];
                7'h76:   rd_nxt = ar_r[1];
                7'h77:   rd_nxt = ar_r[0];
                7'h78:   rd_nxt = win_r;
                7'h79:   rd_nxt = bank_r;
                7'h7A:   rd_nxt = ix_r[2];
                7'h7B:   rd_nxt = ix_r[1];
                7'h7C:   rd_nxt = ix_r[0];
                7'h7D:   rd_nxt = rph_r;
                7'h7E:   rd_nxt = rpl_r;
                default: rd_nxt = psw_r;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata  <= 4'h0;
            rvalid <= 1'b0;
        end else begin
            rvalid <= (req.op != ndm_pkg::NDM_OP_NONE) && !wr_en;
            if ((req.op != ndm_pkg::NDM_OP_NONE) && !wr_en) begin
                rdata <= rd_nxt;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // exported views
    assign table_address_pointer  = {ar_r[3], ar_r[2], ar_r[1], ar_r[0]};
    assign memory_bank_select     = bank_r;
    assign index_and_row_pointer  = {ix_r[2], ix_r[1], ix_r[0]};
    assign gen_reg_pointer        = {rph_r, rpl_r[3:1]}; // [RULE8]
    assign processor_status_flags = psw_r;

endmodule

/* ndm_pkg.sv */
// package: constants and types for the nibble data memory and register map
package ndm_pkg;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned NIB_W  = 4;
    localparam int unsigned PC_W   = 10;
    localparam int unsigned STK_D  = 5;
    localparam int unsigned SP_W   = 3;
    localparam int unsigned ROW_W  = 3;
    localparam int unsigned COL_W  = 4;
    localparam int unsigned NBANK  = 1;

    localparam logic [6:0] HOLE_LO   = 7'h40;
    localparam logic [6:0] HOLE_HI   = 7'h6E;
    localparam logic [6:0] SYS_LO    = 7'h74;
    localparam logic [6:0] SYS_HI    = 7'h7F;
    localparam logic [6:0] CFG_HI    = 7'h3F;
    localparam logic [6:0] AR3_ADDR  = 7'h74;
    localparam logic [6:0] AR0_ADDR  = 7'h77;
    localparam logic [6:0] WIN_ADDR  = 7'h78;
    localparam logic [6:0] BANK_ADDR = 7'h79;
    localparam logic [6:0] IXH_ADDR  = 7'h7A;
    localparam logic [6:0] IXM_ADDR  = 7'h7B;
    localparam logic [6:0] IXL_ADDR  = 7'h7C;
    localparam logic [6:0] RPH_ADDR  = 7'h7D;
    localparam logic [6:0] RPL_ADDR  = 7'h7E;
    localparam logic [6:0] PSW_ADDR  = 7'h7F;

    // writable bit masks; zero bits are fixed at zero
    localparam logic [3:0] AR3_MASK  = 4'h0;
    localparam logic [3:0] AR2_MASK  = 4'h3;
    localparam logic [3:0] AR_MASK   = 4'hF;
    localparam logic [3:0] BANK_MASK = 4'h3;
    localparam logic [3:0] IXH_MASK  = 4'h9;
    localparam logic [3:0] RPH_MASK  = 4'h0;
    localparam logic [3:0] RPL_MASK  = 4'hF;
    localparam logic [3:0] PSW_MASK  = 4'hF;
    localparam logic [3:0] NIB_RST   = 4'h0;
    localparam logic [3:0] HOLE_RD   = 4'h0;

    typedef enum logic [1:0] {
        NDM_OP_NONE,
        NDM_OP_MOV,
        NDM_OP_CFG_RD,
        NDM_OP_CFG_WR
    } ndm_op_t;

    typedef struct packed {
        ndm_op_t          op;
        logic             wr;
        logic             use_gr;
        logic [3:0]       col;
        logic [6:0]       addr;
        logic [3:0]       wdata;
    } ndm_req_t;

    typedef struct packed {
        logic             call;
        logic             ret;
        logic             irq;
        logic             reti;
        logic [9:0]       ret_pc;
    } ndm_flow_t;
endpackage

/* ndm_core_props.sv */
// checker for the nibble memory core ports
`timescale 1ns/1ps
module ndm_core_props (
    input wire logic               sys_clk,
    input wire logic               nrst,
    input wire ndm_pkg::ndm_req_t  req,
    input wire ndm_pkg::ndm_flow_t flow,
    input wire logic [3:0]         rdata,
    input wire logic               rvalid,
    input wire logic [9:0]         pop_pc,
    input wire logic               stack_full,
    input wire logic [15:0]        table_address_pointer,
    input wire logic [3:0]         memory_bank_select,
    input wire logic [11:0]        index_and_row_pointer,
    input wire logic [6:0]         gen_reg_pointer,
    input wire logic [3:0]         processor_status_flags
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire rd_req = req.op == ndm_pkg::NDM_OP_CFG_RD ||
                  (req.op == ndm_pkg::NDM_OP_MOV && !req.wr);
    wire mv_wr = req.op == ndm_pkg::NDM_OP_MOV && req.wr && !req.use_gr;
    sequence s_hole_rd;
        rd_req && !req.use_gr && req.addr >= ndm_pkg::HOLE_LO &&
        req.addr <= ndm_pkg::HOLE_HI;
    endsequence
    sequence s_rpl_wr;
        mv_wr && req.addr == ndm_pkg::RPL_ADDR;
    endsequence
    chk_read_answer: assert property (rd_req |=> rvalid)
        else $error("read without answer");
    chk_no_answer: assert property (!rd_req |=> !rvalid)
        else $error("answer without read");
    chk_hole_zero: assert property (s_hole_rd |=> rdata == 4'h0)
        else $error("hole read not zero");
    chk_irq_clear: assert property (flow.irq && !stack_full |=>
        memory_bank_select == 4'h0 && processor_status_flags == 4'h0)
        else $error("interrupt did not clear bank and status");
    chk_ar_zero: assert property (
        table_address_pointer[15:10] == 6'h00)
        else $error("address fixed bits not zero");
    chk_fixed_zero: assert property (memory_bank_select[3:2] == 2'h0 &&
        index_and_row_pointer[10:9] == 2'h0)
        else $error("fixed bits not zero");
    chk_ptr_high: assert property (gen_reg_pointer[6:3] == 4'h0)
        else $error("pointer bank bits not zero");
    chk_ptr_load: assert property (s_rpl_wr |=>
        gen_reg_pointer[2:0] == $past(req.wdata[3:1]))
        else $error("pointer row not loaded");
    chk_psw_write: assert property (mv_wr && req.addr == ndm_pkg::PSW_ADDR
        |=> processor_status_flags == $past(req.wdata))
        else $error("status write lost");
    chk_cfg_alias: assert property (req.op == ndm_pkg::NDM_OP_CFG_WR &&
        req.addr == ndm_pkg::BANK_ADDR |=>
        memory_bank_select == ($past(req.wdata) & ndm_pkg::BANK_MASK))
        else $error("config write missed bank");
    chk_full_hold: assert property (stack_full && flow.call && !flow.ret
        |=> stack_full)
        else $error("full stack changed on push");
endmodule
bind ndm_core ndm_core_props i_ndm_core_props (.sys_clk(sys_clk),
    .nrst(nrst), .req(req), .flow(flow), .rdata(rdata), .rvalid(rvalid),
    .pop_pc(pop_pc), .stack_full(stack_full),
    .table_address_pointer(table_address_pointer),
    .memory_bank_select(memory_bank_select),
    .index_and_row_pointer(index_and_row_pointer),
    .gen_reg_pointer(gen_reg_pointer),
    .processor_status_flags(processor_status_flags));

/* ndm_cpu_model.sv */
// cpu-side model issuing memory ops and flow pulses
`timescale 1ns/1ps
module ndm_cpu_model (
    input  wire logic          sys_clk,
    input  wire logic          rvalid,
    input  wire logic [3:0]    rdata,
    output ndm_pkg::ndm_req_t  req,
    output ndm_pkg::ndm_flow_t flow
);
    initial begin
        req = '0;
        flow = '0;
    end
    task automatic op(input ndm_pkg::ndm_op_t o, input logic w,
                      input logic g, input logic [6:0] a,
                      input logic [3:0] d, output logic [3:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        #1;
        // hole writes are never issued
        if (!(w && a >= ndm_pkg::HOLE_LO && a <= ndm_pkg::HOLE_HI))
            req = '{o, w, g, a[3:0], a, d};
        @(posedge sys_clk);
        #1;
        req = '0;
        while (!w && rvalid !== 1'b1 && n < 3) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        q = rvalid ? rdata : 4'hx;
    endtask
    task automatic pulse(input logic [3:0] k, input logic [9:0] pc);
        @(posedge sys_clk);
        #1;
        flow = {k, pc};
        @(posedge sys_clk);
        #1;
        flow = '0;
    endtask
endmodule

/* ndm_core_tb.sv */
// self-checking bench for the nibble memory core
`timescale 1ns/1ps
module ndm_core_tb;
    localparam ndm_pkg::ndm_op_t mv = ndm_pkg::NDM_OP_MOV;
    localparam ndm_pkg::ndm_op_t cr = ndm_pkg::NDM_OP_CFG_RD;
    localparam ndm_pkg::ndm_op_t cw = ndm_pkg::NDM_OP_CFG_WR;
    localparam logic [47:0] msk = 48'h03FF_F39F_F0FF;
    logic               sys_clk;
    logic               nrst;
    logic               rvalid;
    logic               sfull;
    logic [3:0]         rdata, bnk, psf, q;
    logic [6:0]         grp, a;
    logic [9:0]         pop;
    logic [11:0]        ixr;
    logic [15:0]        tap;
    ndm_pkg::ndm_req_t  req;
    ndm_pkg::ndm_flow_t flow;
    int                 mismatches, total_checks, i;
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    ndm_cpu_model i_ndm_cpu_model (.sys_clk(sys_clk), .rvalid(rvalid),
        .rdata(rdata), .req(req), .flow(flow));
    ndm_core i_ndm_core (.sys_clk(sys_clk), .nrst(nrst), .req(req),
        .flow(flow), .rdata(rdata), .rvalid(rvalid), .pop_pc(pop),
        .stack_full(sfull), .table_address_pointer(tap),
        .memory_bank_select(bnk), .index_and_row_pointer(ixr),
        .gen_reg_pointer(grp), .processor_status_flags(psf));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic w(input ndm_pkg::ndm_op_t o, input logic [6:0] ad,
                     input logic [3:0] d);
        i_ndm_cpu_model.op(o, 1'b1, 1'b0, ad, d, q);
    endtask
    task automatic r(input ndm_pkg::ndm_op_t o, input logic g,
                     input logic [6:0] ad);
        i_ndm_cpu_model.op(o, 1'b0, g, ad, 4'h0, q);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        test_done;
    end
    initial begin
        nrst = 1'b0;
        mismatches = 0;
        total_checks = 0;
        repeat (2) @(posedge sys_clk);
        #1 nrst = 1'b1;
        chk(tap, 16'h0000);
        chk(16'({ixr, bnk}), 16'h0000);
        chk(16'({grp, psf, rvalid, sfull}), 16'h0000);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            w(mv, 7'(i * 21), 4'(i + 3));
            w(cw, 7'(i * 21), 4'(12 - i));
        end
        for (i = 0; i < 4; i++) begin
            r(mv, 1'b0, 7'(i * 21));
            chk(16'(q), 16'(i + 3));
            r(cr, 1'b0, 7'(i * 21));
            chk(16'(q), 16'(12 - i));
        end
        $display("test memory done");
        for (i = 0; i < 3; i++) begin
            r(mv, 1'b0, 7'(64 + i * 23));
            chk(16'(q), 16'h0000);
            r(cr, 1'b0, 7'(64 + i * 23));
            chk(16'(q), 16'h0000);
        end
        $display("test hole done");
        for (i = 0; i < 12; i++) begin
            a = 7'(116 + i);
            w(mv, a, 4'hF);
            r(mv, 1'b0, a);
            chk(16'(q), 16'(msk[47 - 4 * i -: 4]));
        end
        chk(tap, 16'h03FF);
        chk(16'({ixr, bnk}), 16'h9FF3);
        chk(16'({grp, psf}), 16'h007F);
        r(cr, 1'b0, 7'h7F);
        chk(16'(q), 16'h000F);
        w(cw, 7'h79, 4'h5);
        chk(16'(bnk), 16'h0001);
        w(mv, 7'h70, 4'h6);
        r(cr, 1'b0, 7'h70);
        chk(16'(q), 16'h0006);
        $display("test cpu_control_block done");
        r(mv, 1'b1, 7'h0F);
        chk(16'(q), 16'h000F);
        w(mv, 7'h7E, 4'h2);
        i_ndm_cpu_model.op(mv, 1'b1, 1'b1, 7'h05, 4'hA, q);
        r(mv, 1'b0, 7'h15);
        chk(16'(q), 16'h000A);
        chk(16'(grp), 16'h0001);
        $display("test pointer done");
        for (i = 0; i < 6; i++) begin
            if (i == 4)
                chk(16'(sfull), 16'h0000);
            i_ndm_cpu_model.pulse(4'h8, 10'(i + 256));
        end
        chk(16'(sfull), 16'h0001);
        for (i = 4; i >= 0; i--) begin
            i_ndm_cpu_model.pulse(4'h4, 10'h000);
            chk(16'(pop), 16'(i + 256));
        end
        i_ndm_cpu_model.pulse(4'h2, 10'h2A5);
        chk(16'({bnk, psf}), 16'h0000);
        i_ndm_cpu_model.pulse(4'h1, 10'h000);
        chk(16'({pop, psf}), 16'h2A5F);
        $display("test stack done");
        test_done;
    end
endmodule
